/* File: design/scr_params.svh */
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH

// register addresses
`define SCR_ADDR_CTRL       8'hd0
`define SCR_ADDR_COPY       8'hdf
`define SCR_ADDR_STAT       8'he0
`define SCR_ADDR_CMD_BASE   8'hc0
`define SCR_ADDR_RSLT_BASE  8'he0

// control field positions
`define SCR_BIT_U1_CMD      0
`define SCR_BIT_U1_PTR_LO   1
`define SCR_BIT_U1_PTR_HI   4
`define SCR_BIT_U1_SYNC     6
`define SCR_BIT_COPY_SYNC   7
`define SCR_BIT_U2_CMD      8
`define SCR_BIT_U2_PTR_LO   9
`define SCR_BIT_U2_PTR_HI   12
`define SCR_BIT_U2_SYNC     14
`define SCR_BIT_NEW_FLAG    14

// command entry next pointer field
`define SCR_NXT_LO          3
`define SCR_NXT_HI          6

// reset values
`define SCR_CTRL_RESET      16'h00c0
`define SCR_ZERO16          16'h0000
`define SCR_ZERO15          15'h0000
`define SCR_SYNC_RESET      1'h0
`define SCR_PTR_END         4'h0
`define SCR_ONE4            4'h1
`define SCR_ENTRIES         15
// mask of writable control bits; 15 and 13 read as zero
`define SCR_CTRL_WMASK      16'h5fff

`endif

/* File: design/scr_pkg.sv */
package scr_pkg;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } scr_req_type;

    typedef enum logic [0:0] {
        SCR_IDLE = 1'b0,
        SCR_RUN  = 1'b1
    } scr_unit_state_type;
endpackage

/* File: design/scr_sequencer_regs.sv */
// Overview of operation
// - sync toggle starts unit two when enabled
// - unit two start pointer selects entry 1-15
// - writing one to bit 8 starts unit two
// - sync copies results when copy enable set
// - sync toggle starts unit one when enabled
// - unit one start pointer, zero invalid
// - writing one to bit 0 starts unit one
// - reading copy register copies result buffer
// - status bits mirror channel comparators
// - next pointer zero ends the loop
// - new-result flag set on data, read clears
`timescale 1ns/10ps
`default_nettype none
`include "scr_params.svh"

module scr_sequencer_regs
    import scr_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // register access from the serial front end
    input  wire scr_req_type regReq,
    output logic [15:0]      rdData,
    // sync pin, synchronous to clk
    input  wire logic        syncIn,
    // comparator levels per input channel
    input  wire logic [14:0] compLevel,
    // conversion engine: result buffer write
    input  wire logic        bufWrite,
    input  wire logic [3:0]  bufSlot,
    input  wire logic [15:0] bufData,
    // unit activity: entry under execution, 0 when idle
    output logic [3:0]       unitOneEntry,
    output logic [3:0]       unitTwoEntry,
    input  wire logic        entryDone
);

    // ****************************************
    // register storage
    // ****************************************
    logic [15:0] ctrl_q, ctrl_d;
    logic [14:0] stat_q, stat_d;
    logic        sync_q, sync_d;
    logic [15:0] cmd_q  [1:`SCR_ENTRIES];
    logic [15:0] cmd_d  [1:`SCR_ENTRIES];
    logic [15:0] buf_q  [1:`SCR_ENTRIES];
    logic [15:0] buf_d  [1:`SCR_ENTRIES];
    logic [15:0] rslt_q [1:`SCR_ENTRIES];
    logic [15:0] rslt_d [1:`SCR_ENTRIES];
    logic [15:0] rd_q, rd_d;

    logic syncToggle;
    logic startOne;
    logic startTwo;
    logic copyNow;
    logic ctrlWr;
    logic copyRd;

    // ****************************************
    // access and sync event decode
    // ****************************************
    always_comb begin
        ctrlWr     = regReq.wr && regReq.addr == `SCR_ADDR_CTRL;
        copyRd     = regReq.rd && regReq.addr == `SCR_ADDR_COPY;
        syncToggle = syncIn != sync_q;
        startOne   = 1'b0;
        startTwo   = 1'b0;
        copyNow    = 1'b0;
        // a start bit of one requests a launch of its unit on every write, a zero never does; the unit launches only if idle with a non-zero pointer
        if (ctrlWr && regReq.wdata[`SCR_BIT_U1_CMD]) begin
            startOne = 1'b1;
        end
        if (ctrlWr && regReq.wdata[`SCR_BIT_U2_CMD]) begin
            startTwo = 1'b1;
        end
        // either edge of sync counts; the enables are the ones already stored
        if (syncToggle && ctrl_q[`SCR_BIT_U1_SYNC]) begin
            startOne = 1'b1;
        end
        if (syncToggle && ctrl_q[`SCR_BIT_U2_SYNC]) begin
            startTwo = 1'b1;
        end
        if (copyRd) begin
            copyNow = 1'b1;
        end
        if (syncToggle && ctrl_q[`SCR_BIT_COPY_SYNC]) begin
            copyNow = 1'b1;
        end
    end

    // ****************************************
    // control register
    // ****************************************
    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrlWr) begin
            // bits 15 and 13 are dropped here so they always read back as zero
            ctrl_d = regReq.wdata & `SCR_CTRL_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= `SCR_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ****************************************
    // comparator status and sync sample
    // ****************************************
    always_comb begin
        stat_d = compLevel;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stat_q <= `SCR_ZERO15;
        end else begin
            stat_q <= stat_d;
        end
    end

    always_comb begin
        sync_d = syncIn;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // a high sync pin just after reset is taken as a toggle
            sync_q <= `SCR_SYNC_RESET;
        end else begin
            sync_q <= sync_d;
        end
    end

    // ****************************************
    // command table, result buffer and results
    // ****************************************

    genvar e;
    generate
        for (e = 1; e <= `SCR_ENTRIES; e = e + 1) begin : gEntry
            logic cmdWr;
            logic rsltRd;
            logic bufWr;
            assign cmdWr  = regReq.wr && regReq.addr == (`SCR_ADDR_CMD_BASE + 8'(e));
            assign rsltRd = regReq.rd && regReq.addr == (`SCR_ADDR_RSLT_BASE + 8'(e));
            assign bufWr  = bufWrite && bufSlot == 4'(e);
            always_comb begin
                cmd_d[e] = cmd_q[e];
                if (cmdWr) begin
                    cmd_d[e] = regReq.wdata;
                end
            end

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    cmd_q[e] <= `SCR_ZERO16;
                end else begin
                    cmd_q[e] <= cmd_d[e];
                end
            end

            always_comb begin
                buf_d[e] = buf_q[e];
                // a copied slot is no longer new; fresh data in the same cycle keeps the flag
                if (copyNow) begin
                    buf_d[e][`SCR_BIT_NEW_FLAG] = 1'b0;
                end
                if (bufWr) begin
                    buf_d[e] = bufData;
                    buf_d[e][`SCR_BIT_NEW_FLAG] = 1'b1;
                end
            end

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    buf_q[e] <= `SCR_ZERO16;
                end else begin
                    buf_q[e] <= buf_d[e];
                end
            end

            always_comb begin
                rslt_d[e] = rslt_q[e];
                if (rsltRd) begin
                    rslt_d[e][`SCR_BIT_NEW_FLAG] = 1'b0;
                end
                // a copy in the same cycle as a read wins and brings the fresh flag in
                if (copyNow) begin
                    rslt_d[e] = buf_q[e];
                end
            end

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    rslt_q[e] <= `SCR_ZERO16;
                end else begin
                    rslt_q[e] <= rslt_d[e];
                end
            end
        end
    endgenerate

    // ****************************************
    // read data
    // ****************************************
    always_comb begin
        rd_d = rd_q;
        if (regReq.rd) begin
            rd_d = `SCR_ZERO16;
            if (regReq.addr == `SCR_ADDR_CTRL) begin
                rd_d = ctrl_q;
            end else if (regReq.addr == `SCR_ADDR_STAT) begin
                rd_d = {1'b0, stat_q};
            end else if (regReq.addr > `SCR_ADDR_CMD_BASE
                         && regReq.addr <= `SCR_ADDR_CMD_BASE + 8'(`SCR_ENTRIES)) begin
                rd_d = cmd_q[4'(regReq.addr - `SCR_ADDR_CMD_BASE)];
            end else if (regReq.addr > `SCR_ADDR_RSLT_BASE
                         && regReq.addr <= `SCR_ADDR_RSLT_BASE + 8'(`SCR_ENTRIES)) begin
                rd_d = rslt_q[4'(regReq.addr - `SCR_ADDR_RSLT_BASE)];
            end
        end
    end
    assign rdData = rd_q;

    // ****************************************
    // execution units
    // ****************************************
    scr_unit_state_type unit_q [2];
    scr_unit_state_type unit_d [2];
    logic [3:0]         pc_q [2];
    logic [3:0]         pc_d [2];
    logic [3:0]         startPtr [2];
    logic               start [2];
    // the pointer is the one the control word holds after this edge, so a write
    // that sets the pointer and starts the unit at once uses the new pointer
    assign startPtr[0] = ctrl_d[`SCR_BIT_U1_PTR_HI:`SCR_BIT_U1_PTR_LO];
    assign startPtr[1] = ctrl_d[`SCR_BIT_U2_PTR_HI:`SCR_BIT_U2_PTR_LO];
    assign start[0]    = startOne;
    assign start[1]    = startTwo;

    genvar u;
    generate
        for (u = 0; u < 2; u = u + 1) begin : gUnit
            // unit two only advances while unit one is idle, sharing one converter
            logic       advance;
            logic [3:0] nextPtr;
            assign advance = entryDone && (u == 0 || unit_q[0] == SCR_IDLE);

            // the table is only indexed while running, where the pointer is never zero
            always_comb begin
                nextPtr = `SCR_PTR_END;
                if (unit_q[u] == SCR_RUN) begin
                    nextPtr = cmd_q[pc_q[u]][`SCR_NXT_HI:`SCR_NXT_LO];
                end
            end

            always_comb begin
                unit_d[u] = unit_q[u];
                pc_d[u]   = pc_q[u];
                unique case (unit_q[u])
                    SCR_IDLE: begin
                        // a zero start pointer leaves the unit idle
                        if (start[u] && startPtr[u] != `SCR_PTR_END) begin
                            unit_d[u] = SCR_RUN;
                            pc_d[u]   = startPtr[u];
                        end
                    end
                    SCR_RUN: begin
                        if (advance) begin
                            pc_d[u] = nextPtr;
                            if (nextPtr == `SCR_PTR_END) begin
                                unit_d[u] = SCR_IDLE;
                            end
                        end
                    end
                endcase
            end

            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    unit_q[u] <= SCR_IDLE;
                    pc_q[u]   <= `SCR_PTR_END;
                end else begin
                    unit_q[u] <= unit_d[u];
                    pc_q[u]   <= pc_d[u];
                end
            end
        end
    endgenerate
    assign unitOneEntry = pc_q[0];
    assign unitTwoEntry = pc_q[1];

    // ****************************************
    // read data register
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_q <= `SCR_ZERO16;
        end else begin
            rd_q <= rd_d;
        end
    end

endmodule
`default_nettype wire

/* File: verification/scr_sequencer_regs_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module scr_sequencer_regs_asserts
    import scr_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire scr_req_type regReq,
    input wire logic [15:0] rdData,
    input wire logic        syncIn,
    input wire logic [14:0] compLevel,
    input wire logic        bufWrite,
    input wire logic [3:0]  bufSlot,
    input wire logic [15:0] bufData,
    input wire logic [3:0]  unitOneEntry,
    input wire logic [3:0]  unitTwoEntry,
    input wire logic        entryDone
);
    logic [15:0] ctlQ;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // shadow of the control word so sync launches can be predicted
    always_ff @(posedge clk) begin
        if (!rst_n) ctlQ <= 16'h00c0;
        else if (regReq.wr && regReq.addr == 8'hd0) ctlQ <= regReq.wdata;
    end
    sequence s_tgl;
        $past(rst_n) && syncIn != $past(syncIn) && !regReq.wr;
    endsequence
    property p_ctlRd; regReq.rd && regReq.addr == 8'hd0 |=> rdData == ($past(ctlQ) & 16'h5fff); endproperty
    a_ctlRd: assert property (p_ctlRd) else $error("control readback");
    property p_stat; regReq.rd && regReq.addr == 8'he0 && $past(rst_n) |=> rdData == {1'b0, $past(compLevel, 2)};
    endproperty
    a_stat: assert property (p_stat) else $error("status readback");
    property p_u1Cmd; regReq.wr && regReq.addr == 8'hd0 && regReq.wdata[0] && regReq.wdata[4:1] != 4'h0
        && unitOneEntry == 4'h0 |=> unitOneEntry == $past(regReq.wdata[4:1]); endproperty
    a_u1Cmd: assert property (p_u1Cmd) else $error("unit one command start");
    property p_u1Off; regReq.wr && regReq.addr == 8'hd0 && !regReq.wdata[0] && unitOneEntry == 4'h0
        && $past(rst_n) && $stable(syncIn) |=> unitOneEntry == 4'h0; endproperty
    a_u1Off: assert property (p_u1Off) else $error("unit one started by a zero bit");
    property p_u2Cmd; regReq.wr && regReq.addr == 8'hd0 && regReq.wdata[8] && regReq.wdata[12:9] != 4'h0
        && unitTwoEntry == 4'h0 |=> unitTwoEntry == $past(regReq.wdata[12:9]); endproperty
    a_u2Cmd: assert property (p_u2Cmd) else $error("unit two command start");
    property p_u1Zero; regReq.wr && regReq.addr == 8'hd0 && regReq.wdata[4:1] == 4'h0 && unitOneEntry == 4'h0
        |=> unitOneEntry == 4'h0; endproperty
    a_u1Zero: assert property (p_u1Zero) else $error("unit one started from pointer zero");
    property p_u2Zero; regReq.wr && regReq.addr == 8'hd0 && regReq.wdata[12:9] == 4'h0 && unitTwoEntry == 4'h0
        |=> unitTwoEntry == 4'h0; endproperty
    a_u2Zero: assert property (p_u2Zero) else $error("unit two started from pointer zero");
    property p_sync1; s_tgl ##0 (ctlQ[6] && ctlQ[4:1] != 4'h0 && unitOneEntry == 4'h0)
        |=> unitOneEntry == $past(ctlQ[4:1]); endproperty
    a_sync1: assert property (p_sync1) else $error("unit one sync start");
    property p_noSync1; s_tgl ##0 (!ctlQ[6] && unitOneEntry == 4'h0) |=> unitOneEntry == 4'h0; endproperty
    a_noSync1: assert property (p_noSync1) else $error("unit one false sync start");
    property p_sync2; s_tgl ##0 (ctlQ[14] && ctlQ[12:9] != 4'h0 && unitTwoEntry == 4'h0)
        |=> unitTwoEntry == $past(ctlQ[12:9]); endproperty
    a_sync2: assert property (p_sync2) else $error("unit two sync start");
endmodule
bind scr_sequencer_regs scr_sequencer_regs_asserts i_scr_sequencer_regs_asserts (.clk(clk), .rst_n(rst_n),
    .regReq(regReq), .rdData(rdData), .syncIn(syncIn), .compLevel(compLevel), .bufWrite(bufWrite), .bufSlot(bufSlot),
    .bufData(bufData), .unitOneEntry(unitOneEntry), .unitTwoEntry(unitTwoEntry), .entryDone(entryDone));
`default_nettype wire

/* File: verification/scr_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module scr_host_model
    import scr_pkg::*;
(
    input  wire logic        clk,
    output var scr_req_type  regReq,
    input  wire logic [15:0] rdData
);
    initial regReq = '0;
    // one strobe per call, held over exactly one rising edge; data read once it has settled
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
        @(negedge clk);
        regReq = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        regReq = '0;
        @(negedge clk);
        q = rdData;
    endtask
endmodule
`default_nettype wire

/* File: verification/scr_sequencer_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module scr_sequencer_regs_tb
    import scr_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, syncIn = 1'b0, bufWrite = 1'b0, entryDone = 1'b0;
    logic [14:0] compLevel = 15'h5a3c;
    logic [3:0]  bufSlot = 4'h0, unitOneEntry, unitTwoEntry;
    logic [15:0] bufData = 16'h0000, rdData, v;
    scr_req_type regReq;
    int          err_count = 0, check_count = 0;
    always #12.5 clk = ~clk;
    scr_host_model i_scr_host_model (.clk(clk), .regReq(regReq), .rdData(rdData));
    scr_sequencer_regs i_scr_sequencer_regs (.clk(clk), .rst_n(rst_n), .regReq(regReq), .rdData(rdData),
        .syncIn(syncIn), .compLevel(compLevel), .bufWrite(bufWrite), .bufSlot(bufSlot), .bufData(bufData),
        .unitOneEntry(unitOneEntry), .unitTwoEntry(unitTwoEntry), .entryDone(entryDone));
    task automatic close_out;
        if (err_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        i_scr_host_model.xfer(1'b1, a, d, v);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        i_scr_host_model.xfer(1'b0, a, 16'h0000, v);
        chk(v, e);
    endtask
    // toggle sync and/or finish an entry, then give the launch two edges to land
    task automatic step(input logic tg, input logic dn, input logic [7:0] e);
        @(negedge clk);
        syncIn = syncIn ^ tg;
        entryDone = dn;
        @(negedge clk);
        entryDone = 1'b0;
        @(negedge clk);
        chk({8'h00, unitTwoEntry, unitOneEntry}, {8'h00, e});
    endtask
    task automatic bw(input logic [15:0] d);
        @(negedge clk);
        bufWrite = 1'b1;
        bufSlot = 4'h4;
        bufData = d;
        @(negedge clk);
        bufWrite = 1'b0;
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        rd(8'hd0, 16'h00c0);
        rd(8'he0, 16'h5a3c);
        compLevel = 15'h25c3;
        rd(8'he0, 16'h25c3);
        rd(8'hc0, 16'h0000);
        wr(8'hc3, 16'h0028);
        wr(8'hd0, 16'h00c6);
        step(1'b0, 1'b0, 8'h00);
        wr(8'hd0, 16'h0101);
        step(1'b0, 1'b0, 8'h00);
        wr(8'hd0, 16'h00c7);
        step(1'b0, 1'b0, 8'h03);
        step(1'b0, 1'b1, 8'h05);
        step(1'b0, 1'b1, 8'h00);
        wr(8'hd0, 16'h0bc0);
        step(1'b0, 1'b0, 8'h50);
        step(1'b0, 1'b1, 8'h00);
        wr(8'hd0, 16'h44c6);
        step(1'b1, 1'b0, 8'h23);
        step(1'b0, 1'b1, 8'h25);
        step(1'b0, 1'b1, 8'h20);
        step(1'b0, 1'b1, 8'h00);
        bw(16'h0123);
        wr(8'hd0, 16'h0006);
        step(1'b1, 1'b0, 8'h00);
        rd(8'he4, 16'h0000);
        rd(8'hdf, 16'h0000);
        rd(8'he4, 16'h4123);
        rd(8'he4, 16'h0123);
        wr(8'hd0, 16'h0080);
        bw(16'h0055);
        step(1'b1, 1'b0, 8'h00);
        rd(8'he4, 16'h4055);
        rd(8'hdf, 16'h0000);
        rd(8'he4, 16'h0055);
        close_out();
    end
    initial begin
        repeat (3000) @(negedge clk);
        err_count++;
        close_out();
    end
endmodule
`default_nettype wire
